// ---- pmisf_pkg.sv ----
// shared constants for the interrupt status flag block
package pmisf_pkg;

  // register geometry
  localparam int REG_W = 16;
  localparam int ADDR_W = 8;
  localparam logic [REG_W-1:0] FLAGS_RESET = 16'h0000;

  // register offsets on the control interface
  localparam logic [ADDR_W-1:0] SYSTEM_FAULT_FLAGS_ADDR = 8'h1a;
  localparam logic [ADDR_W-1:0] UNDERVOLTAGE_FLAGS_ADDR = 8'h1c;
  localparam logic [ADDR_W-1:0] OVERCURRENT_FLAGS_ADDR = 8'h1d;
  localparam logic [ADDR_W-1:0] PIN_EVENT_FLAGS_ADDR = 8'h1e;

  // clear strobe index per register
  localparam int NUM_REGS = 4;
  localparam int SEL_SYS = 0;
  localparam int SEL_UV = 1;
  localparam int SEL_OC = 2;
  localparam int SEL_PIN = 3;

  // system fault register fields (tail only)
  localparam int SYS_N = 4;
  localparam int WATCHDOG_EXPIRY_BIT = 0;
  localparam int HOT_DIE_BIT = 1;
  localparam int WARM_DIE_BIT = 2;
  localparam int BROWNOUT_BIT = 3;

  // under-voltage register fields
  localparam int CONV_N = 6;
  localparam int CONV_LSB = 0;
  localparam int LINREG_N = 4;
  localparam int LINREG_LSB = 8;

  // over-current register field
  localparam int OC_N = 1;
  localparam int CURRENT_LIMIT_BIT = 15;

  // pin event register field, pin n at bit n
  localparam int PIN_N = 13;
  localparam int PIN_LSB = 0;

endpackage : pmisf_pkg

// ---- pmisf_flag_bank.sv ----
// bank of sticky flags, set by source events and cleared by a host read
module pmisf_flag_bank #(
  parameter int WIDTH = 4,
  parameter bit RISING_EDGE = 1'b1
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  // event sources and clearing read
  input wire logic [WIDTH-1:0] source,
  input wire logic clear,
  // captured flags
  output logic [WIDTH-1:0] flag,
  output logic [WIDTH-1:0] set
);

  logic [WIDTH-1:0] prev;
  logic [WIDTH-1:0] next_prev;
  logic [WIDTH-1:0] next_flag;

  // per-bit set term: rising edge of the source, or the qualified source itself
  for (genvar i = 0; i < WIDTH; i++) begin : g_set
    if (RISING_EDGE) begin : g_edge
      assign set[i] = clk_en & source[i] & ~prev[i];
    end else begin : g_level
      assign set[i] = clk_en & source[i];
    end
  end

  // set wins over the clearing read so no event is lost
  always_comb begin
    next_prev = prev;
    next_flag = flag;
    if (clk_en) begin
      next_prev = source;
      next_flag = (flag & ~{WIDTH{clear}}) | set; // RQ5 RQ11
    end
  end

  // registers, all zero after reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prev <= '0;
      flag <= '0; // RQ12
    end else begin
      prev <= next_prev;
      flag <= next_flag;
    end
  end

endmodule : pmisf_flag_bank

// ---- pmisf_read_port.sv ----
// register read decode, read data capture and clear-on-read strobes
module pmisf_read_port (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  // host read request
  input wire logic rd_en,
  input wire logic [pmisf_pkg::ADDR_W-1:0] rd_addr,
  // register images
  input wire logic [pmisf_pkg::REG_W-1:0] sys_word,
  input wire logic [pmisf_pkg::REG_W-1:0] uv_word,
  input wire logic [pmisf_pkg::REG_W-1:0] oc_word,
  input wire logic [pmisf_pkg::REG_W-1:0] pin_word,
  // answer and clear strobes
  output logic [pmisf_pkg::REG_W-1:0] rd_data,
  output logic rd_valid,
  output logic [pmisf_pkg::NUM_REGS-1:0] clear
);

  logic [pmisf_pkg::REG_W-1:0] sel_word;
  logic [pmisf_pkg::REG_W-1:0] next_rd_data;
  logic next_rd_valid;

  // address decode; unmapped addresses read zero and clear nothing
  always_comb begin
    sel_word = '0;
    clear = '0;
    unique case (rd_addr)
      pmisf_pkg::SYSTEM_FAULT_FLAGS_ADDR: begin
        sel_word = sys_word;
        clear[pmisf_pkg::SEL_SYS] = rd_en & clk_en;
      end
      pmisf_pkg::UNDERVOLTAGE_FLAGS_ADDR: begin
        sel_word = uv_word;
        clear[pmisf_pkg::SEL_UV] = rd_en & clk_en;
      end
      pmisf_pkg::OVERCURRENT_FLAGS_ADDR: begin
        sel_word = oc_word;
        clear[pmisf_pkg::SEL_OC] = rd_en & clk_en;
      end
      pmisf_pkg::PIN_EVENT_FLAGS_ADDR: begin
        sel_word = pin_word;
        clear[pmisf_pkg::SEL_PIN] = rd_en & clk_en;
      end
      default: begin
        sel_word = '0;
      end
    endcase
  end

  // read data is held until the next read, valid pulses one cycle
  always_comb begin
    next_rd_data = rd_data;
    next_rd_valid = rd_valid;
    if (clk_en) begin
      next_rd_valid = rd_en;
      if (rd_en) begin
        next_rd_data = sel_word;
      end
    end
  end

  // answer registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= pmisf_pkg::FLAGS_RESET;
      rd_valid <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

endmodule : pmisf_read_port

// ---- pmisf_top.sv ----
// sticky clear-on-read interrupt status flags: system fault, under-voltage,
// over-current and pin event registers
// Function
// RQ1 - brownout_flag, bit 3 of system fault, set on comparator rising edge
// RQ2 - warm_die_flag, bit 2, set on rising edge of over-115C indication
// RQ3 - hot_die_flag, bit 1, set on rising edge of over-140C indication
// RQ4 - watchdog_expiry_flag, bit 0, set on watchdog timeout rising edge
// RQ5 - flags stay set until the host reads their register
// RQ6 - linear regulator 1 to 4 under-voltage edges set bits 8 to 11
// RQ7 - converter 1 to 6 under-voltage edges set bits 0 to 5
// RQ8 - current_limit_flag, bit 15 of over-current, set on rising edge
// RQ9 - pin event register: pin n at bit n, pins 0 to 12
// RQ10 - pin trigger condition comes qualified from per-pin configuration logic
// RQ11 - unused bits read zero; event during clearing read keeps flag set
// RQ12 - all flags zero after reset; set only by events, cleared only by reads
module pmisf_top (
  // clock, reset and clock enable
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  // system fault sources, levels
  input wire logic brownout_level,
  input wire logic die_over_115,
  input wire logic die_over_140,
  input wire logic watchdog_timeout,
  // regulator sources, levels
  input wire logic [pmisf_pkg::LINREG_N-1:0] linreg_undervolt,
  input wire logic [pmisf_pkg::CONV_N-1:0] conv_undervolt,
  input wire logic current_limit_overcurrent,
  // pin trigger events, already qualified by per-pin configuration
  input wire logic [pmisf_pkg::PIN_N-1:0] pin_trigger,
  // host read port
  input wire logic rd_en,
  input wire logic [pmisf_pkg::ADDR_W-1:0] rd_addr,
  output logic [pmisf_pkg::REG_W-1:0] rd_data,
  output logic rd_valid,
  // live register images for the interrupt gating logic
  output logic [pmisf_pkg::REG_W-1:0] system_fault_flags,
  output logic [pmisf_pkg::REG_W-1:0] undervoltage_flags,
  output logic [pmisf_pkg::REG_W-1:0] overcurrent_flags,
  output logic [pmisf_pkg::REG_W-1:0] pin_event_flags
);

  logic [pmisf_pkg::NUM_REGS-1:0] clear;
  logic [pmisf_pkg::SYS_N-1:0] sys_src;
  logic [pmisf_pkg::SYS_N-1:0] sys_flag;
  logic [pmisf_pkg::SYS_N-1:0] sys_set;
  logic [pmisf_pkg::LINREG_N+pmisf_pkg::CONV_N-1:0] uv_src;
  logic [pmisf_pkg::LINREG_N+pmisf_pkg::CONV_N-1:0] uv_flag;
  logic [pmisf_pkg::LINREG_N+pmisf_pkg::CONV_N-1:0] uv_set;
  logic [pmisf_pkg::OC_N-1:0] oc_flag;
  logic [pmisf_pkg::OC_N-1:0] oc_set;
  logic [pmisf_pkg::PIN_N-1:0] pin_flag;
  logic [pmisf_pkg::PIN_N-1:0] pin_set;

  // gather system fault sources in bit order
  always_comb begin
    sys_src = '0;
    sys_src[pmisf_pkg::BROWNOUT_BIT] = brownout_level; // RQ1
    sys_src[pmisf_pkg::WARM_DIE_BIT] = die_over_115; // RQ2
    sys_src[pmisf_pkg::HOT_DIE_BIT] = die_over_140; // RQ3
    sys_src[pmisf_pkg::WATCHDOG_EXPIRY_BIT] = watchdog_timeout; // RQ4
  end

  // under-voltage sources: converters low, linear regulators high
  assign uv_src = {linreg_undervolt, conv_undervolt}; // RQ6 RQ7

  // system fault flags, rising edge captured
  pmisf_flag_bank #(
    .WIDTH(pmisf_pkg::SYS_N),
    .RISING_EDGE(1'b1)
  ) u_sys (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .source(sys_src),
    .clear(clear[pmisf_pkg::SEL_SYS]),
    .flag(sys_flag),
    .set(sys_set)
  );

  // regulator under-voltage flags, rising edge captured
  pmisf_flag_bank #(
    .WIDTH(pmisf_pkg::LINREG_N + pmisf_pkg::CONV_N),
    .RISING_EDGE(1'b1)
  ) u_uv (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .source(uv_src),
    .clear(clear[pmisf_pkg::SEL_UV]),
    .flag(uv_flag),
    .set(uv_set)
  );

  // current limit switch over-current flag, rising edge captured
  pmisf_flag_bank #(
    .WIDTH(pmisf_pkg::OC_N),
    .RISING_EDGE(1'b1)
  ) u_oc (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .source(current_limit_overcurrent), // RQ8
    .clear(clear[pmisf_pkg::SEL_OC]),
    .flag(oc_flag),
    .set(oc_set)
  );

  // pin event flags; trigger already qualified so every asserted cycle sets
  pmisf_flag_bank #(
    .WIDTH(pmisf_pkg::PIN_N),
    .RISING_EDGE(1'b0)
  ) u_pin (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .source(pin_trigger), // RQ10
    .clear(clear[pmisf_pkg::SEL_PIN]),
    .flag(pin_flag),
    .set(pin_set)
  );

  // register images; undocumented bit positions stay zero
  always_comb begin
    system_fault_flags = pmisf_pkg::FLAGS_RESET; // RQ11
    undervoltage_flags = pmisf_pkg::FLAGS_RESET;
    overcurrent_flags = pmisf_pkg::FLAGS_RESET;
    pin_event_flags = pmisf_pkg::FLAGS_RESET;
    system_fault_flags[pmisf_pkg::SYS_N-1:0] = sys_flag;
    undervoltage_flags[pmisf_pkg::CONV_LSB +: pmisf_pkg::CONV_N] =
      uv_flag[pmisf_pkg::CONV_N-1:0]; // RQ7
    undervoltage_flags[pmisf_pkg::LINREG_LSB +: pmisf_pkg::LINREG_N] =
      uv_flag[pmisf_pkg::CONV_N +: pmisf_pkg::LINREG_N]; // RQ6
    overcurrent_flags[pmisf_pkg::CURRENT_LIMIT_BIT] = oc_flag[0]; // RQ8
    pin_event_flags[pmisf_pkg::PIN_LSB +: pmisf_pkg::PIN_N] = pin_flag; // RQ9
  end

  // host read and clear-on-read strobes
  pmisf_read_port u_read (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .sys_word(system_fault_flags),
    .uv_word(undervoltage_flags),
    .oc_word(overcurrent_flags),
    .pin_word(pin_event_flags),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .clear(clear) // RQ5
  );

  // checks on the captured flags and the read behaviour
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  property p_brownout;
    clk_en && brownout_level && !u_sys.prev[pmisf_pkg::BROWNOUT_BIT]
      |=> system_fault_flags[pmisf_pkg::BROWNOUT_BIT];
  endproperty
  a_brownout: assert property (p_brownout) else $error("brownout edge not captured"); // RQ1

  property p_warm_die;
    clk_en && die_over_115 && !u_sys.prev[pmisf_pkg::WARM_DIE_BIT]
      |=> system_fault_flags[pmisf_pkg::WARM_DIE_BIT];
  endproperty
  a_warm_die: assert property (p_warm_die) else $error("warm die edge not captured"); // RQ2

  property p_hot_die;
    clk_en && die_over_140 && !u_sys.prev[pmisf_pkg::HOT_DIE_BIT]
      |=> system_fault_flags[pmisf_pkg::HOT_DIE_BIT];
  endproperty
  a_hot_die: assert property (p_hot_die) else $error("hot die edge not captured"); // RQ3

  property p_hot_level_only;
    clk_en && die_over_140 && u_sys.prev[pmisf_pkg::HOT_DIE_BIT]
      && clear[pmisf_pkg::SEL_SYS]
      |=> !system_fault_flags[pmisf_pkg::HOT_DIE_BIT];
  endproperty
  a_hot_level_only: assert property (p_hot_level_only) else $error("level re-set flag"); // RQ3

  property p_watchdog;
    clk_en && watchdog_timeout && !u_sys.prev[pmisf_pkg::WATCHDOG_EXPIRY_BIT]
      |=> system_fault_flags[pmisf_pkg::WATCHDOG_EXPIRY_BIT];
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog edge not captured"); // RQ4

  property p_sticky;
    !clear[pmisf_pkg::SEL_SYS] && system_fault_flags != pmisf_pkg::FLAGS_RESET
      |=> (system_fault_flags & $past(system_fault_flags)) == $past(system_fault_flags);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without a read"); // RQ5

  property p_read_clears;
    clear[pmisf_pkg::SEL_UV] && uv_set == '0
      |=> undervoltage_flags == pmisf_pkg::FLAGS_RESET ##0 rd_valid
      ##0 rd_data == $past(undervoltage_flags);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read not cleared"); // RQ5

  property p_linreg;
    clk_en && linreg_undervolt[0] && !u_uv.prev[pmisf_pkg::CONV_N]
      |=> undervoltage_flags[pmisf_pkg::LINREG_LSB];
  endproperty
  a_linreg: assert property (p_linreg) else $error("regulator 1 flag misplaced"); // RQ6

  property p_conv;
    clk_en && conv_undervolt[pmisf_pkg::CONV_N-1] && !u_uv.prev[pmisf_pkg::CONV_N-1]
      |=> undervoltage_flags[pmisf_pkg::CONV_LSB + pmisf_pkg::CONV_N - 1];
  endproperty
  a_conv: assert property (p_conv) else $error("converter 6 flag misplaced"); // RQ7

  property p_overcurrent;
    clk_en && current_limit_overcurrent && !u_oc.prev[0]
      |=> overcurrent_flags[pmisf_pkg::CURRENT_LIMIT_BIT];
  endproperty
  a_overcurrent: assert property (p_overcurrent) else $error("overcurrent not captured"); // RQ8

  property p_pin_map;
    clk_en && pin_trigger[pmisf_pkg::PIN_N-1]
      |=> pin_event_flags[pmisf_pkg::PIN_LSB + pmisf_pkg::PIN_N - 1];
  endproperty
  a_pin_map: assert property (p_pin_map) else $error("pin 12 event not captured"); // RQ9 RQ10

  property p_unused_zero;
    system_fault_flags[pmisf_pkg::REG_W-1:pmisf_pkg::SYS_N] == '0
      && undervoltage_flags[pmisf_pkg::LINREG_LSB-1:pmisf_pkg::CONV_N] == '0
      && overcurrent_flags[pmisf_pkg::CURRENT_LIMIT_BIT-1:0] == '0
      && pin_event_flags[pmisf_pkg::REG_W-1:pmisf_pkg::PIN_N] == '0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit nonzero"); // RQ11

  property p_set_wins;
    clear[pmisf_pkg::SEL_PIN] && pin_set[pmisf_pkg::PIN_N-1]
      |=> pin_event_flags[pmisf_pkg::PIN_LSB + pmisf_pkg::PIN_N - 1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost during read"); // RQ11

  property p_only_events_set;
    !clk_en |=> $stable(pin_event_flags) && $stable(overcurrent_flags);
  endproperty
  a_only_events_set: assert property (p_only_events_set) else $error("frozen flag moved"); // RQ12

  property p_brown_level;
    clk_en && brownout_level && u_sys.prev[pmisf_pkg::BROWNOUT_BIT]
      && clear[pmisf_pkg::SEL_SYS]
      |=> !system_fault_flags[pmisf_pkg::BROWNOUT_BIT];
  endproperty
  a_brown_level: assert property (p_brown_level) else $error("steady level re-set flag"); // RQ1

  property p_warm_level;
    clk_en && die_over_115 && u_sys.prev[pmisf_pkg::WARM_DIE_BIT]
      && clear[pmisf_pkg::SEL_SYS]
      |=> !system_fault_flags[pmisf_pkg::WARM_DIE_BIT];
  endproperty
  a_warm_level: assert property (p_warm_level) else $error("steady level re-set flag"); // RQ2

  property p_wdog_level;
    clk_en && watchdog_timeout && u_sys.prev[pmisf_pkg::WATCHDOG_EXPIRY_BIT]
      && clear[pmisf_pkg::SEL_SYS]
      |=> !system_fault_flags[pmisf_pkg::WATCHDOG_EXPIRY_BIT];
  endproperty
  a_wdog_level: assert property (p_wdog_level) else $error("steady level re-set flag"); // RQ4

  property p_oc_level;
    clk_en && current_limit_overcurrent && u_oc.prev[0]
      && clear[pmisf_pkg::SEL_OC]
      |=> !overcurrent_flags[pmisf_pkg::CURRENT_LIMIT_BIT];
  endproperty
  a_oc_level: assert property (p_oc_level) else $error("steady level re-set flag"); // RQ8

  property p_sys_set_wins;
    clear[pmisf_pkg::SEL_SYS] && sys_set[pmisf_pkg::BROWNOUT_BIT]
      |=> system_fault_flags[pmisf_pkg::BROWNOUT_BIT];
  endproperty
  a_sys_set_wins: assert property (p_sys_set_wins) else $error("event lost during read"); // RQ11

  property p_oc_sticky;
    !clear[pmisf_pkg::SEL_OC] && overcurrent_flags[pmisf_pkg::CURRENT_LIMIT_BIT]
      |=> overcurrent_flags[pmisf_pkg::CURRENT_LIMIT_BIT];
  endproperty
  a_oc_sticky: assert property (p_oc_sticky) else $error("flag lost without a read"); // RQ5

  property p_pin_read_clears;
    clear[pmisf_pkg::SEL_PIN] && pin_set == '0
      |=> pin_event_flags == pmisf_pkg::FLAGS_RESET
      ##0 rd_data == $past(pin_event_flags);
  endproperty
  a_pin_read_clears: assert property (p_pin_read_clears) else $error("read not cleared"); // RQ5

  property p_unmapped;
    clk_en && rd_en && clear == '0
      |=> rd_valid && rd_data == pmisf_pkg::FLAGS_RESET;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero"); // RQ11

  property p_sys_quiet;
    sys_set == '0 && system_fault_flags == pmisf_pkg::FLAGS_RESET
      |=> system_fault_flags == pmisf_pkg::FLAGS_RESET;
  endproperty
  a_sys_quiet: assert property (p_sys_quiet) else $error("flag set with no event"); // RQ12

  property p_oc_quiet;
    !oc_set[0] && !overcurrent_flags[pmisf_pkg::CURRENT_LIMIT_BIT]
      |=> !overcurrent_flags[pmisf_pkg::CURRENT_LIMIT_BIT];
  endproperty
  a_oc_quiet: assert property (p_oc_quiet) else $error("flag set with no event"); // RQ12

endmodule : pmisf_top

// ---- pmisf_host_model.sv ----
// host side model: issues register reads on the read port and collects the answers
module pmisf_host_model (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // read port toward the device
  output logic rd_en,
  output logic [pmisf_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [pmisf_pkg::REG_W-1:0] rd_data,
  input wire logic rd_valid
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle port at time zero
  initial begin
    rd_en = 1'b0;
    rd_addr = 8'h00;
  end

  // one read, entered just after a rising edge; answer taken one edge later
  task automatic read(input logic [7:0] addr, output logic [15:0] data, output bit ok);
    int n;
    rd_en = 1'b1;
    rd_addr = addr;
    @(posedge clock);
    #1;
    rd_en = 1'b0;
    rd_addr = ~addr; // released address never shows the stale value
    for (n = 0; n < 3 && rd_valid !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    ok = (rd_valid === 1'b1) && (reset_n === 1'b1);
    data = rd_data;
    // idle edge so a following read never re-drives the strobe in this step
    @(posedge clock);
    #1;
  endtask : read
endmodule : pmisf_host_model

// ---- tb_pmisf_top.sv ----
// self-checking testbench for the sticky clear-on-read status flags
module tb_pmisf_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [3:0] sys_src = 4'h0;
  logic [3:0] linreg = 4'h0;
  logic [5:0] conv = 6'h00;
  logic cur_lim = 1'b0;
  logic [12:0] pin_trig = 13'h0000;
  logic rd_en;
  logic rd_valid;
  logic [7:0] rd_addr;
  logic [15:0] rd_data, sys_img, uv_img, oc_img, pin_img;
  int miscompares = 0;
  int n_compared = 0;

  // 100 MHz clock
  always #5 clock = ~clock;

  // device and host
  pmisf_top DUT (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
    .brownout_level(sys_src[3]), .die_over_115(sys_src[2]), .die_over_140(sys_src[1]),
    .watchdog_timeout(sys_src[0]), .linreg_undervolt(linreg), .conv_undervolt(conv),
    .current_limit_overcurrent(cur_lim), .pin_trigger(pin_trig), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .system_fault_flags(sys_img), .undervoltage_flags(uv_img),
    .overcurrent_flags(oc_img), .pin_event_flags(pin_img));
  pmisf_host_model host (.clock(clock), .reset_n(reset_n), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));

  // advance to just after a rising edge
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
    end
  endtask : tick

  // compare one 16-bit result
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // read through the host and compare the answer
  task automatic rd(input logic [7:0] addr, input logic [15:0] exp);
    logic [15:0] d;
    bit ok;
    host.read(addr, d, ok);
    if (!ok) begin
      miscompares++;
      $display("mismatch rd_valid expected 1 seen 0");
    end
    chk("rd_data", exp, d);
  endtask : rd

  // report and end the run
  task automatic tally_and_finish();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // reset values on images and reads, unmapped offset reads zero
  task automatic t_reset();
    chk("images", 16'h0000, sys_img | uv_img | oc_img | pin_img);
    rd(8'h1a, 16'h0000);
    rd(8'h1c, 16'h0000);
    rd(8'h1d, 16'h0000);
    rd(8'h1e, 16'h0000);
    rd(8'h1b, 16'h0000);
  endtask : t_reset

  // fault sources one by one, sticky while high, clear on read, no re-set on level
  task automatic t_sys();
    logic [15:0] exp;
    exp = 16'h0000;
    for (int k = 0; k < 4; k++) begin
      sys_src[k] = 1'b1;
      tick(1);
      exp[k] = 1'b1;
      chk("sys image", exp, sys_img);
    end
    tick(3);
    chk("sys held", 16'h000f, sys_img);
    rd(8'h1a, 16'h000f);
    tick(2);
    chk("sys level", 16'h0000, sys_img);
    sys_src = 4'h0;
    tick(1);
    sys_src[0] = 1'b1; // watchdog as a one-cycle pulse
    tick(1);
    sys_src[0] = 1'b0;
    tick(2);
    chk("sys pulse", 16'h0001, sys_img);
    rd(8'h1a, 16'h0001);
  endtask : t_sys

  // regulator and converter under-voltage mapping
  task automatic t_uv();
    logic [15:0] exp;
    exp = 16'h0000;
    for (int k = 0; k < 4; k++) begin
      linreg[k] = 1'b1;
      tick(1);
      exp[8+k] = 1'b1;
      chk("uv image", exp, uv_img);
    end
    for (int k = 0; k < 6; k++) begin
      conv[k] = 1'b1;
      tick(1);
      exp[k] = 1'b1;
      chk("uv image", exp, uv_img);
    end
    chk("other images", 16'h0000, sys_img | oc_img | pin_img);
    rd(8'h1c, 16'h0f3f);
    rd(8'h1c, 16'h0000);
    linreg = 4'h0;
    conv = 6'h00;
  endtask : t_uv

  // over-current flag, untouched by an unmapped read
  task automatic t_oc();
    cur_lim = 1'b1;
    tick(1);
    chk("oc image", 16'h8000, oc_img);
    rd(8'h1f, 16'h0000);
    chk("oc kept", 16'h8000, oc_img);
    rd(8'h1d, 16'h8000);
    rd(8'h1d, 16'h0000);
    cur_lim = 1'b0;
  endtask : t_oc

  // pin n at bit n; qualified trigger sets every high cycle
  task automatic t_pin();
    pin_trig = 13'h1555;
    tick(1);
    pin_trig = 13'h0aaa;
    chk("pin image", 16'h1555, pin_img);
    tick(1);
    pin_trig = 13'h1000;
    chk("pin image", 16'h1fff, pin_img);
    rd(8'h1e, 16'h1fff);
    chk("pin level", 16'h1000, pin_img);
    pin_trig = 13'h0000;
    tick(1);
    rd(8'h1e, 16'h1000);
    chk("pin clear", 16'h0000, pin_img);
  endtask : t_pin

  // event in the clearing read cycle survives for the next read
  task automatic t_race();
    sys_src[3] = 1'b1;
    rd(8'h1a, 16'h0000);
    chk("sys race", 16'h0008, sys_img);
    rd(8'h1a, 16'h0008);
    sys_src = 4'h0;
  endtask : t_race

  // clock enable low freezes capture; mid-run reset zeroes all flags
  task automatic t_freeze_reset();
    clk_en = 1'b0;
    conv[0] = 1'b1;
    tick(2);
    chk("frozen", 16'h0000, uv_img);
    clk_en = 1'b1;
    tick(1);
    chk("thawed", 16'h0001, uv_img);
    conv = 6'h00;
    pin_trig = 13'h0001;
    tick(1);
    pin_trig = 13'h0000;
    reset_n = 1'b0;
    #1;
    chk("reset", 16'h0000, sys_img | uv_img | oc_img | pin_img);
    tick(2);
    reset_n = 1'b1;
    tick(1);
    rd(8'h1c, 16'h0000);
  endtask : t_freeze_reset

  // main sequence
  initial begin
    tick(5);
    reset_n = 1'b1;
    tick(1);
    t_reset();
    t_sys();
    t_uv();
    t_oc();
    t_pin();
    t_race();
    t_freeze_reset();
    tally_and_finish();
  end
endmodule : tb_pmisf_top
